// ==== hdl/mbhi_host_port.sv ====
/*
  Multiplexed address/data host port with two selectable bus timings.
  It latches the address, takes write data, drives read data and blocks access on power fail.
  Assumes host strobes are synchronous to core_clk and the register store sits behind the user side ports.
  The store must hold reg_rdata steady while a read data phase lasts.
*/
`timescale 1ns/100ps
module mbhi_host_port (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        bus_timing_select,
  input  wire logic                        address_strobe,
  input  wire logic                        data_strobe,
  input  wire logic                        rw,
  input  wire logic                        chip_select_n,
  input  wire logic                        power_fail,
  input  wire logic [mbhi_pkg::DATA_W-1:0] addr_data_bus_in,
  output logic      [mbhi_pkg::DATA_W-1:0] addr_data_bus_out,
  output logic                             addr_data_bus_oe,
  input  wire logic                        osc_input,
  output logic                             osc_output,
  output logic      [mbhi_pkg::ADDR_W-1:0] reg_addr,
  output logic                             reg_addr_valid,
  output logic                             reg_wr,
  output logic      [mbhi_pkg::DATA_W-1:0] reg_wdata,
  output logic                             reg_rd,
  input  wire logic [mbhi_pkg::DATA_W-1:0] reg_rdata
);
  import mbhi_pkg::*;

  logic                mode_q;
  logic                as_rise, as_fall;
  logic                ds_lvl, ds_rise, ds_fall;
  logic                rw_lvl, rw_rise, rw_fall;
  logic                sel;
  logic                rd_phase;
  logic                wr_event;
  logic                rd_start;
  mbhi_addr_state_t    ast_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                oe_q;
  logic                osc_q;
  logic                wr_q;
  logic [DATA_W-1:0]   wdata_q;
  logic                rd_q;
  logic                valid_q;
  logic                addr_ok;
  logic                wr_go;
  logic                rd_go;

  // One edge detector per strobe; the address strobe level is taken from the pin itself, not from its detector.
  mbhi_edge u_as (
    .core_clk(core_clk),
    .rst     (rst),
    .sig     (address_strobe),
    .level   (),
    .rise    (as_rise),
    .fall    (as_fall)
  );

  mbhi_edge u_ds (
    .core_clk(core_clk),
    .rst     (rst),
    .sig     (data_strobe),
    .level   (ds_lvl),
    .rise    (ds_rise),
    .fall    (ds_fall)
  );

  mbhi_edge u_rw (
    .core_clk(core_clk),
    .rst     (rst),
    .sig     (rw),
    .level   (rw_lvl),
    .rise    (rw_rise),
    .fall    (rw_fall)
  );

  // The address is loaded straight from the shared lines, so both widths must agree.
  if (ADDR_W != DATA_W) begin : g_width_check
    $error("Address width must equal the shared bus width.");
  end

  if (DATA_W == 0) begin : g_zero_check
    $error("The shared bus needs at least one bit.");
  end

  // The strap is caught while reset is held; a pulled-down pin reads low.
  // Changing the strap in mid-run has no effect until the next reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= bus_timing_select;
    end
  end

  // Power fail masks chip select so no access reaches the store.
  // Chip select matters at the strobe edges that start an access and, for the output enable, all through the read data phase.
  assign sel = ~chip_select_n & ~power_fail;

  // Decode the strobe pair into a read phase, a write edge and a read start for the strapped timing.
  always_comb begin
    if (mode_q == MODE_STROBE) begin
      rd_phase = ds_lvl & rw_lvl;
      wr_event = ds_fall & ~rw_lvl;
      rd_start = (ds_rise & rw_lvl) | (rw_rise & ds_lvl);
    end else begin
      rd_phase = ~ds_lvl & rw_lvl;
      wr_event = rw_rise & ds_lvl;
      rd_start = (ds_fall & rw_lvl) | (rw_rise & ~ds_lvl);
    end
  end

  // An access needs a live address and a select not masked by power fail.
  assign addr_ok = (ast_q == MBHI_ADDR);
  assign wr_go   = wr_event & sel & addr_ok;
  assign rd_go   = rd_start & sel & addr_ok;

  // Address is captured on every strobe fall, selected or not.
  // A rising address strobe wins over everything but reset so a stale address is never reused.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_q <= ADDR_RST;
      ast_q  <= MBHI_IDLE;
    end else if (as_rise) begin
      ast_q <= MBHI_IDLE;
    end else if (as_fall) begin
      addr_q <= addr_data_bus_in;
      ast_q  <= MBHI_ADDR;
    end else begin
      case (ast_q)
        MBHI_ADDR: begin
          if ((wr_event | rd_start) & ~sel) begin
            ast_q <= MBHI_INVALID;
          end
        end
        MBHI_IDLE, MBHI_INVALID: begin
          ast_q <= ast_q;
        end
        default: begin
          ast_q <= MBHI_IDLE;
        end
      endcase
    end
  end

  // Write data is taken on every write edge; only a selected one raises the strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q    <= 1'b0;
      wdata_q <= DATA_RST;
    end else begin
      wr_q <= wr_go;
      if (wr_event) begin
        wdata_q <= addr_data_bus_in;
      end
    end
  end

  // One pulse at the start of each selected read so the store can advance.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_go;
    end
  end

  // Drive only during a selected read data phase; float otherwise.
  // The address strobe term keeps the lines free while a new address is placed.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= rd_phase & sel & addr_ok & ~address_strobe;
    end
  end

  // Read data follows the store during the whole read phase and is held after it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= DATA_RST;
    end else if (rd_phase) begin
      rdata_q <= reg_rdata;
    end
  end

  // Registered copy of the address-live state so the output comes from a flop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else if (as_rise) begin
      valid_q <= 1'b0;
    end else if (as_fall) begin
      valid_q <= 1'b1;
    end else if (addr_ok & (wr_event | rd_start) & ~sel) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= addr_ok;
    end
  end

  // Inverted oscillator; left unused when an external source drives the input.
  // It is sampled by core_clk, so it only mirrors slow oscillator inputs.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= ~osc_input;
    end
  end

  // Every output is a flop; these lines only rename them.
  assign addr_data_bus_out = rdata_q;
  assign addr_data_bus_oe  = oe_q;
  assign osc_output        = osc_q;
  assign reg_addr          = addr_q;
  assign reg_addr_valid    = valid_q;
  assign reg_wr            = wr_q;
  assign reg_wdata         = wdata_q;
  assign reg_rd            = rd_q;
endmodule : mbhi_host_port

// ==== hdl/mbhi_pkg.sv ====
/*
  Constants and types for the multiplexed address/data host port.
  Assumes a single 20 MHz core clock and host strobes sampled synchronously.
*/
package mbhi_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam logic [7:0]  ADDR_RST  = 8'h00;
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic        MODE_STROBE   = 1'b1;
  localparam logic        MODE_SEPARATE = 1'b0;
  typedef enum logic [1:0] {
    MBHI_IDLE,
    MBHI_ADDR,
    MBHI_INVALID
  } mbhi_addr_state_t;
endpackage : mbhi_pkg

// ==== hdl/mbhi_edge.sv ====
/*
  Edge detector for one synchronous strobe input.
  Assumes the input is already synchronous to core_clk.
*/
`timescale 1ns/100ps
module mbhi_edge (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic sig,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic prev_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Seeding with the pin level avoids a false edge on the first cycle after reset.
      prev_q <= sig;
    end else begin
      prev_q <= sig;
    end
  end

  assign level = sig;
  assign rise  = sig & ~prev_q;
  assign fall  = ~sig & prev_q;
endmodule : mbhi_edge

// ==== testbench/mbhi_port_sva.sv ====
/* Checker on the host port pins, bound to every mbhi_host_port. Assumes one clock and synchronous strobes. */
`timescale 1ns/100ps
module mbhi_port_sva (
  input wire logic       core_clk, rst, bus_timing_select, address_strobe, data_strobe, rw, chip_select_n,
  input wire logic       power_fail, addr_data_bus_oe, reg_addr_valid, reg_wr, reg_rd,
  input wire logic [7:0] addr_data_bus_in, addr_data_bus_out, reg_addr, reg_rdata
);
  wire rd_ph = bus_timing_select ? (data_strobe & rw) : (~data_strobe & rw);
  wire sel   = ~chip_select_n & ~power_fail & reg_addr_valid;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_addr_latch: assert property ($fell(address_strobe) |=> reg_addr == $past(addr_data_bus_in)) else $error("addr");
  chk_addr_drop: assert property ($rose(address_strobe) |=> !reg_addr_valid) else $error("addr drop");
  chk_wr_strobe: assert property (bus_timing_select && $fell(data_strobe) && !rw && sel |=> reg_wr) else $error("wr1");
  chk_wr_sep: assert property (!bus_timing_select && $rose(rw) && data_strobe && sel |=> reg_wr) else $error("wr0");
  chk_no_access: assert property (chip_select_n || power_fail |=> !reg_wr && !reg_rd) else $error("blocked");
  chk_oe_cause: assert property (addr_data_bus_oe |-> $past(rd_ph)) else $error("oe");
  chk_oe_end: assert property ($fell(rd_ph) |=> !addr_data_bus_oe) else $error("oe end");
  chk_rd_data: assert property (addr_data_bus_oe |-> addr_data_bus_out == $past(reg_rdata)) else $error("rd");
  chk_rd_start: assert property ($rose(rd_ph) && sel |=> reg_rd && addr_data_bus_oe) else $error("rd start");
  cover property (reg_wr);
  cover property (reg_rd);
  cover property (power_fail && $fell(address_strobe));
endmodule : mbhi_port_sva
bind mbhi_host_port mbhi_port_sva u_sva (.core_clk, .rst, .bus_timing_select, .address_strobe, .data_strobe, .rw,
  .chip_select_n, .power_fail, .addr_data_bus_oe, .reg_addr_valid, .reg_wr, .reg_rd, .addr_data_bus_in,
  .addr_data_bus_out, .reg_addr, .reg_rdata);

// ==== testbench/mbhi_host_model.sv ====
/* Host processor model on the shared bus. Assumes the bench calls idle and cyc just after a rising edge. */
`timescale 1ns/100ps
module mbhi_host_model (
  input wire logic       core_clk, mode, oe,
  input wire logic [7:0] dout,
  output logic           as, ds, rw, cs_n,
  output logic [7:0]     bus
);
  logic [7:0] drv = 8'h00;
  assign bus = oe ? dout : drv;
  task automatic idle();
    as = 1'b0;
    ds = ~mode;
    rw = 1'b1;
    cs_n = 1'b1;
  endtask : idle
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic cyc(input logic rd, sel, input logic [7:0] a, d, output logic [7:0] q);
    cs_n = ~sel;
    as = 1'b1;
    drv = a;
    step(2);
    as = 1'b0;
    step(2);
    drv = rd ? ~a : d;
    rw = rd;
    ds = mode | ~rd;
    step(4);
    q = bus;
    ds = ~mode;
    step(2);
    rw = 1'b1;
    step(2);
    cs_n = 1'b1;
    // A released bus shows the inverse of its last value.
    drv = ~drv;
    step(1);
  endtask : cyc
endmodule : mbhi_host_model

// ==== testbench/mbhi_host_port_tb.sv ====
/* Bench for mbhi_host_port with the host model on the bus side. Assumes nothing outside this file set. */
`timescale 1ns/100ps
module mbhi_host_port_tb;
  logic       core_clk = 1'b0, rst = 1'b1, mode = 1'b0, power_fail = 1'b0, osc_input = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic       as, ds, rw, cs_n, oe, reg_wr, reg_rd, av, osc_out;
  logic       osc_exp = 1'b0;
  logic [7:0] bus, dout, reg_wdata, reg_addr, wd, wa, q;
  int         fails = 0, cmp_count = 0, wr_n = 0, rd_n = 0, cyc_n = 0;
  always #25 core_clk = ~core_clk;
  mbhi_host_port DUT (.core_clk, .rst, .bus_timing_select(mode), .address_strobe(as), .data_strobe(ds), .rw,
    .chip_select_n(cs_n), .power_fail, .addr_data_bus_in(bus), .addr_data_bus_out(dout), .addr_data_bus_oe(oe),
    .osc_input, .osc_output(osc_out), .reg_addr, .reg_addr_valid(av), .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  mbhi_host_model host (.core_clk, .mode, .oe, .dout, .as, .ds, .rw, .cs_n, .bus);
  task automatic chk(input string n, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  always @(posedge core_clk) begin
    cyc_n++;
    osc_exp <= ~osc_input;
    if (cyc_n % 8 == 0) osc_input <= ~osc_input;
    if (reg_wr === 1'b1) begin
      wr_n++;
      wd = reg_wdata;
      wa = reg_addr;
    end
    if (reg_rd === 1'b1) rd_n++;
    if (cyc_n > 2000) begin
      fails++;
      stop_test();
    end
  end
  task automatic do_reset(input logic m);
    host.step(1);
    rst = 1'b1;
    mode = m;
    host.idle();
    host.step(6);
    rst = 1'b0;
  endtask : do_reset
  task automatic t_write(input logic [7:0] a, d);
    wr_n = 0;
    host.cyc(1'b0, 1'b1, a, d, q);
    chk("wr count", 8'(wr_n), 8'h01);
    chk("wr addr", wa, a);
    chk("wr data", wd, d);
    chk("addr valid", {7'h00, av}, 8'h01);
    chk("osc", {7'h00, osc_out}, {7'h00, osc_exp});
  endtask : t_write
  task automatic t_read(input logic [7:0] a, r);
    reg_rdata = r;
    rd_n = 0;
    host.cyc(1'b1, 1'b1, a, 8'h00, q);
    chk("rd data", q, r);
    chk("rd count", 8'(rd_n), 8'h01);
    chk("oe after", {7'h00, oe}, 8'h00);
  endtask : t_read
  task automatic t_blocked(input logic [7:0] a, d);
    wr_n = 0;
    host.cyc(1'b0, 1'b0, a, d, q);
    chk("unselected", 8'(wr_n), 8'h00);
    chk("addr dropped", {7'h00, av}, 8'h00);
    power_fail = 1'b1;
    host.cyc(1'b0, 1'b1, a, d, q);
    power_fail = 1'b0;
    chk("power fail", 8'(wr_n), 8'h00);
  endtask : t_blocked
  initial begin
    host.idle();
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      t_write(8'h0e, 8'h5a);
      t_read(8'h0e, 8'ha5);
      t_blocked(8'h31, 8'hc3);
      t_write(8'h7f, 8'hff);
    end
    stop_test();
  end
endmodule : mbhi_host_port_tb
